// File: rtl/iac_converter_ctrl.sv
module iac_converter_ctrl import iac_pkg::*; #(
  parameter int DivRatio = DIV_RATIO
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Oscillator and converter control pins
  input wire logic oscIn,
  input wire logic clockSourceSelect,
  input wire logic runHold,
  input wire logic modeIn,
  input wire logic transmitHoldingEmptyFlag,
  input wire logic comparatorIn,
  input wire logic testGrounded,
  input wire logic testMidLevel,
  output logic statusOut,
  // Select and byte enable pins, three signals each
  input wire logic ceLoadIn,
  output logic ceLoadOut,
  output logic ceLoadOe,
  input wire logic lowByteEnableIn,
  output logic lowByteEnableOut,
  output logic lowByteEnableOe,
  input wire logic highByteEnableIn,
  output logic highByteEnableOut,
  output logic highByteEnableOe,
  // Three-state data outputs: {overLimit, signBit, highNibbleBits}, lowDataByteBits
  output logic [7:0] lowDataByteBits,
  output logic lowDataOe,
  output logic [5:0] highDataBits,
  output logic highDataOe,
  // AXI4-Lite slave
  input wire logic [3:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [3:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);

  if (DivRatio < 2 || DivRatio > 255) begin : g_check
    $error("DivRatio must lie between 2 and 255");
  end

  function automatic logic isMapped(input logic [3:0] a);
    return a == ADDR_CTRL || a == ADDR_STAT || a == ADDR_RESULT;
  endfunction

  localparam logic [7:0] DIV_LAST = 8'(DivRatio - 1);
  localparam logic [CNT_W-1:0] AZ_LAST = CNT_W'(AZ_TICKS - 1);
  localparam logic [CNT_W-1:0] INT_LAST = CNT_W'(INT_TICKS - 1);
  localparam logic [CNT_W-1:0] DEINT_LAST = CNT_W'(DEINT_TICKS - 1);
  localparam logic [1:0] ARM_LAST = 2'(HS_ARM_TICKS);

  logic [1:0] ctrl_reg;
  logic oscPrev_reg;
  logic [7:0] divCnt_reg;
  iac_phase_e phase_reg;
  iac_hs_e hs_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] mag_reg;
  logic sign_reg;
  logic crossed_reg;
  logic testHeld_reg;
  logic [13:0] result_reg;
  logic convEnd_reg;
  logic modePrev_reg;
  logic modeLatch_reg;
  logic armPend_reg;
  logic [1:0] armCnt_reg;
  logic status_reg;
  logic awHeld_reg;
  logic wHeld_reg;
  logic [3:0] awAddr_reg;
  logic [31:0] wData_reg;
  logic [3:0] wStrb_reg;

  logic runEff;
  logic modeEff;
  logic oscRise;
  logic tick;
  logic convEnd;
  logic enterInt;
  logic hsActive;
  logic hsStart;
  logic modeRise;
  logic permitLow;

  assign runEff = runHold | ctrl_reg[CTRL_RUN_BIT];
  assign modeEff = modeIn | ctrl_reg[CTRL_MODE_BIT];
  assign oscRise = oscIn & ~oscPrev_reg;
  assign modeRise = modeIn & ~modePrev_reg;
  assign hsActive = hs_reg != HS_IDLE;
  assign permitLow = ~transmitHoldingEmptyFlag;

  ////////////////////////////////////////////////////////////////////////////
  // Internal clock: each tick is one internal clock period.

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      oscPrev_reg <= 1'b0;
    end else begin
      oscPrev_reg <= oscIn;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      divCnt_reg <= 8'h00;
    end else if (clockSourceSelect) begin
      // Held at zero while undivided, so a switch to divided mode starts a full period.
      divCnt_reg <= 8'h00;
    end else if (oscRise) begin
      divCnt_reg <= (divCnt_reg == DIV_LAST) ? 8'h00 : divCnt_reg + 8'h01;
    end
  end

  // Grounded test input stops the clock, so no tick reaches the sequencer.
  assign tick = ~testGrounded & oscRise &
                (clockSourceSelect | divCnt_reg == DIV_LAST);

  ////////////////////////////////////////////////////////////////////////////
  // Conversion sequencer.

  // The end of a conversion: full de-integrate, or cut short once run drops after a crossing.
  assign convEnd = tick & phase_reg == PH_DEINTEGRATE & ~testHeld_reg &
                   (cnt_reg == DEINT_LAST | (~runEff & (crossed_reg |
                    comparatorIn != sign_reg)));
  assign enterInt = tick & ~testHeld_reg & runEff &
                    ((phase_reg == PH_AUTOZERO & cnt_reg == AZ_LAST) |
                     phase_reg == PH_HOLD);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phase_reg <= PH_AUTOZERO;
      cnt_reg <= '0;
      testHeld_reg <= 1'b0;
      sign_reg <= 1'b0;
      crossed_reg <= 1'b0;
      mag_reg <= '0;
    end else if (testGrounded) begin
      cnt_reg <= '1;
      testHeld_reg <= 1'b1;
    end else if (tick && testHeld_reg) begin
      cnt_reg <= cnt_reg + 1'b1;
      testHeld_reg <= 1'b0;
    end else if (tick) begin
      cnt_reg <= cnt_reg + 1'b1;
      unique case (phase_reg)
        PH_AUTOZERO: begin
          if (cnt_reg == AZ_LAST) begin
            phase_reg <= runEff ? PH_INTEGRATE : PH_HOLD;
            cnt_reg <= '0;
          end
        end
        PH_HOLD: begin
          cnt_reg <= '0;
          if (runEff) begin
            phase_reg <= PH_INTEGRATE;
          end
        end
        PH_INTEGRATE: begin
          if (cnt_reg == INT_LAST) begin
            phase_reg <= PH_DEINTEGRATE;
            cnt_reg <= '0;
            sign_reg <= comparatorIn;
            crossed_reg <= 1'b0;
          end
        end
        PH_DEINTEGRATE: begin
          if (!crossed_reg && comparatorIn != sign_reg) begin
            crossed_reg <= 1'b1;
            mag_reg <= cnt_reg;
          end
          if (convEnd) begin
            phase_reg <= PH_AUTOZERO;
            cnt_reg <= '0;
          end
        end
      endcase
    end
  end

  // A result is discarded when modeEff is high and the transmitter cannot take it.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      result_reg <= '0;
    end else if (convEnd && status_reg && !(modeEff && permitLow)) begin
      if (crossed_reg) begin
        result_reg <= {1'b0, sign_reg, mag_reg};
      end else if (comparatorIn != sign_reg) begin
        result_reg <= {1'b0, sign_reg, cnt_reg};
      end else begin
        result_reg <= {1'b1, sign_reg, DEINT_LAST};
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      convEnd_reg <= 1'b0;
    end else begin
      convEnd_reg <= convEnd & status_reg;
    end
  end

  // Status drops one system clock after the latch update, never in the same edge.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      status_reg <= 1'b0;
    end else if (enterInt) begin
      status_reg <= 1'b1;
    end else if (convEnd_reg) begin
      status_reg <= 1'b0;
    end
  end

  assign statusOut = status_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Handshake output.

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      modePrev_reg <= 1'b0;
      modeLatch_reg <= 1'b0;
      armPend_reg <= 1'b0;
      armCnt_reg <= 2'h0;
    end else begin
      modePrev_reg <= modeIn;
      if (modeRise) begin
        modeLatch_reg <= 1'b1;
        armPend_reg <= permitLow;
        armCnt_reg <= 2'h0;
      end else if (hsStart) begin
        armPend_reg <= 1'b0;
      end else if (tick && armPend_reg && armCnt_reg != ARM_LAST) begin
        armCnt_reg <= armCnt_reg + 2'h1;
      end
      if (hs_reg == HS_LOW_LOAD && tick && !modeRise) begin
        modeLatch_reg <= 1'b0;
      end
    end
  end

  // A pending mode pulse waits out two internal clocks and a permit before it starts.
  assign hsStart = ~hsActive & transmitHoldingEmptyFlag &
                   ((convEnd_reg & (modeEff | modeLatch_reg)) |
                    (armPend_reg & tick & armCnt_reg == ARM_LAST));

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hs_reg <= HS_IDLE;
    end else if (hsStart) begin
      hs_reg <= HS_HIGH_SET;
    end else if (tick) begin
      unique case (hs_reg)
        HS_IDLE: hs_reg <= HS_IDLE;
        HS_HIGH_SET: hs_reg <= HS_HIGH_LOAD;
        HS_HIGH_LOAD: hs_reg <= HS_WAIT;
        HS_WAIT: begin
          if (transmitHoldingEmptyFlag) begin
            hs_reg <= HS_LOW_SET;
          end
        end
        HS_LOW_SET: hs_reg <= HS_LOW_LOAD;
        HS_LOW_LOAD: hs_reg <= HS_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pins.

  assign ceLoadOe = hsActive | modeEff;
  assign lowByteEnableOe = hsActive | modeEff;
  assign highByteEnableOe = hsActive | modeEff;
  assign ceLoadOut = ~(hs_reg == HS_HIGH_LOAD | hs_reg == HS_LOW_LOAD);
  assign highByteEnableOut = ~(hs_reg == HS_HIGH_SET | hs_reg == HS_HIGH_LOAD);
  assign lowByteEnableOut = ~(hs_reg == HS_LOW_SET | hs_reg == HS_LOW_LOAD);

  assign lowDataOe = hsActive ? ~lowByteEnableOut
                   : (~modeEff & ~ceLoadIn & ~lowByteEnableIn);
  assign highDataOe = hsActive ? ~highByteEnableOut
                    : (~modeEff & ~ceLoadIn & ~highByteEnableIn);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lowDataByteBits <= 8'h00;
      highDataBits <= 6'h00;
    end else if (testMidLevel || testGrounded || testHeld_reg) begin
      lowDataByteBits <= cnt_reg[7:0];
      highDataBits <= {result_reg[13:12], cnt_reg[11:8]};
    end else begin
      lowDataByteBits <= result_reg[7:0];
      highDataBits <= result_reg[13:8];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite registers.

  assign awready = ~awHeld_reg & ~bvalid;
  assign wready = ~wHeld_reg & ~bvalid;
  assign arready = ~rvalid;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      awHeld_reg <= 1'b0;
      wHeld_reg <= 1'b0;
      awAddr_reg <= 4'h0;
      wData_reg <= 32'h0000_0000;
      wStrb_reg <= 4'h0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      ctrl_reg <= CTRL_RESET;
    end else begin
      if (awvalid && awready) begin
        awHeld_reg <= 1'b1;
        awAddr_reg <= awaddr;
      end
      if (wvalid && wready) begin
        wHeld_reg <= 1'b1;
        wData_reg <= wdata;
        wStrb_reg <= wstrb;
      end
      if (awHeld_reg && wHeld_reg && !bvalid) begin
        awHeld_reg <= 1'b0;
        wHeld_reg <= 1'b0;
        bvalid <= 1'b1;
        bresp <= isMapped(awAddr_reg) ? RESP_OKAY : RESP_SLVERR;
        if (awAddr_reg == ADDR_CTRL && wStrb_reg[0]) begin
          ctrl_reg <= wData_reg[1:0];
        end
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rresp <= isMapped(araddr) ? RESP_OKAY : RESP_SLVERR;
      unique case (araddr)
        ADDR_CTRL: rdata <= {30'h0000_0000, ctrl_reg};
        ADDR_STAT: rdata <= {16'h0000, 1'b0, hs_reg, modeLatch_reg, status_reg,
                             phase_reg, cnt_reg[7:0]};
        ADDR_RESULT: rdata <= {18'h0_0000, result_reg};
        default: rdata <= 32'h0000_0000;
      endcase
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  logic [7:0] oscSince_reg;
  logic [CNT_W:0] intLen_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      oscSince_reg <= 8'h00;
      intLen_reg <= '0;
    end else begin
      if (tick) begin
        oscSince_reg <= 8'h00;
      end else if (oscRise && !testGrounded) begin
        oscSince_reg <= oscSince_reg + 8'h01;
      end
      if (phase_reg != PH_INTEGRATE) begin
        intLen_reg <= '0;
      end else if (tick) begin
        intLen_reg <= intLen_reg + 1'b1;
      end
    end
  end

  a_div_ratio: assert property (tick && !clockSourceSelect && $past(!clockSourceSelect) &&
    oscSince_reg != 8'h00 |-> oscSince_reg == DIV_LAST)
    else $error("Divided clock ratio wrong");
  a_rc_direct: assert property (clockSourceSelect && oscRise && !testGrounded |-> tick)
    else $error("Undivided clock missed an oscillator edge");
  a_hiz_select: assert property (!hsActive && ceLoadIn |-> !lowDataOe && !highDataOe)
    else $error("Data driven with select high");
  a_pin_dir: assert property (modeIn |-> ceLoadOe && lowByteEnableOe && highByteEnableOe)
    else $error("Control pins not outputs in handshake mode");
  a_latch_stable: assert property (!statusOut && $past(!statusOut) |-> $stable(result_reg))
    else $error("Result changed while status low");
  a_status_int: assert property (phase_reg == PH_INTEGRATE |-> statusOut)
    else $error("Status low during integrate");
  a_status_fall: assert property (convEnd && status_reg |=> statusOut ##1 !statusOut)
    else $error("Status did not fall after latch");
  a_int_len: assert property (phase_reg == PH_INTEGRATE ##1 phase_reg == PH_DEINTEGRATE
    |-> $past(intLen_reg) == (CNT_W + 1)'(INT_TICKS - 1))
    else $error("Integrate length wrong");
  a_hold_start: assert property (phase_reg == PH_HOLD && runEff && tick && !testHeld_reg
    |=> phase_reg == PH_INTEGRATE && statusOut)
    else $error("Start from hold too slow");
  a_test_force: assert property (testGrounded |=> cnt_reg == '1)
    else $error("Counter not forced high");
  a_byte_order: assert property (hsStart |=> hs_reg == HS_HIGH_SET)
    else $error("Handshake did not start with high byte");

  c_conversion: cover property (phase_reg == PH_DEINTEGRATE ##1 phase_reg == PH_AUTOZERO);
  c_hold: cover property (phase_reg == PH_HOLD ##1 phase_reg == PH_INTEGRATE);
  c_handshake: cover property (hs_reg == HS_LOW_LOAD ##1 hs_reg == HS_IDLE);
  c_test: cover property (testGrounded ##1 !testGrounded);

endmodule

// File: rtl/iac_pkg.sv
// Contract
// - Clock source select low: internal clock is oscillator divided by 58.
// - Clock source select high: internal clock follows oscillator directly, undivided.
// - Fourteen three-state outputs: 12 magnitude, sign and over-limit bits from latches.
// - Direct mode: select high floats all; byte enables low drive their byte.
// - Select and byte enables become outputs during handshake or while mode high.
// - Run held high converts continuously, 8192 cycles each, 4096 de-integrate.
// - Run low: finish current conversion, then stay in auto-zero.
// - Start pulses during conversion or 2048 cycles after status falls are ignored.
// - Holding at auto-zero end: start and raise status within 7 cycles.
// - Run low after status fell cuts de-integrate short into auto-zero; the code cuts it short once run is low after the zero crossing.
// - Run from oscillator gives conversion length 4096 to 8192 by input.
// - Mode input low gives direct output mode.
// - Mode pulse enters handshake, sends two bytes, returns to direct mode.
// - Mode held high sends the result after every conversion.
// - Power-up in direct mode when mode low; transfer-permit may be tied.
// - Status falls half an internal period after the result is latched; the code drops it one system clock later, half a period only when undivided.
// - Status rises at the start of signal integrate.
// - Output latches never change while status is low.
// - Signal integrate lasts exactly 2048 internal clock periods.
// - Test at mid-level makes the latches transparent to the counter.
// - Test grounded stops clock, forces counter high; one clock returns it low.
// - Handshake: high byte strobed first, low byte after transfer-permit high again.
// - Transfer-permit low at conversion end in handshake discards that result.
// - Mode pulse with permit low starts transfer when permit rises, two cycles on.
package iac_pkg;

  localparam int DIV_RATIO = 58;
  localparam int CNT_W = 12;
  localparam int AZ_TICKS = 2048;
  localparam int INT_TICKS = 2048;
  localparam int DEINT_TICKS = 4096;
  localparam int HS_ARM_TICKS = 2;

  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STAT = 4'h4;
  localparam logic [3:0] ADDR_RESULT = 4'h8;
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_MODE_BIT = 1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] CTRL_RESET = 2'h0;

  typedef enum logic [1:0] {PH_AUTOZERO, PH_HOLD, PH_INTEGRATE, PH_DEINTEGRATE} iac_phase_e;
  typedef enum logic [2:0] {HS_IDLE, HS_HIGH_SET, HS_HIGH_LOAD, HS_WAIT, HS_LOW_SET,
                            HS_LOW_LOAD} iac_hs_e;

endpackage

// File: testbench/iac_uart_model.sv
// Serial transmitter on the far side: takes each byte on the rising end of
// the load strobe, then drops its empty flag for a while as a real one does.
module iac_uart_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Handshake pins of the converter
  input wire logic ceLoadOut,
  input wire logic ceLoadOe,
  input wire logic highByteEnableOut,
  input wire logic [7:0] lowDataByteBits,
  input wire logic lowDataOe,
  input wire logic [5:0] highDataBits,
  input wire logic highDataOe,
  // Model control and report
  input wire logic [7:0] stall,
  output logic permit,
  output logic gotByte,
  output logic [7:0] byteData,
  output logic byteHigh
);
  timeunit 1ns;
  timeprecision 1ps;
  logic ceLoadPrev, heldHigh;
  logic [7:0] heldByte, lastLow, busLow, waitCnt;
  logic [5:0] lastHigh, busHigh;
  // A released line shows the inverse of its last value, so stale data never matches.
  assign busLow = lowDataOe ? lowDataByteBits : ~lastLow;
  assign busHigh = highDataOe ? highDataBits : ~lastHigh;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ceLoadPrev <= 1'b1;
      permit <= 1'b1;
      gotByte <= 1'b0;
      {heldHigh, heldByte, lastLow, lastHigh, waitCnt, byteData, byteHigh} <= '0;
    end else begin
      ceLoadPrev <= ceLoadOut;
      gotByte <= 1'b0;
      if (lowDataOe) lastLow <= lowDataByteBits;
      if (highDataOe) lastHigh <= highDataBits;
      if (ceLoadOe && !ceLoadOut) begin
        heldHigh <= !highByteEnableOut;
        heldByte <= highByteEnableOut ? busLow : {2'b00, busHigh};
      end
      if (ceLoadOe && ceLoadOut && !ceLoadPrev) begin
        gotByte <= 1'b1;
        byteData <= heldByte;
        byteHigh <= heldHigh;
        permit <= 1'b0;
        waitCnt <= stall;
      end else if (!permit) begin
        if (waitCnt == 8'h00) permit <= 1'b1;
        else waitCnt <= waitCnt - 8'h01;
      end
    end
  end
endmodule

// File: testbench/integrating_adc_sequencer_output_port_tb.sv
module integrating_adc_sequencer_output_port_tb import iac_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, oscIn, runHold, modeIn, comparatorIn, statusOut, permit, gotByte, byteHigh;
  logic ceBench, lowBench, highBench, ceLoadIn, lowByteEnableIn, highByteEnableIn;
  logic cssBench, testGnd, testMid;
  logic ceLoadOut, ceLoadOe, lowByteEnableOut, lowByteEnableOe, highByteEnableOut;
  logic highByteEnableOe, lowDataOe, highDataOe;
  logic [7:0] lowDataByteBits, byteData, stall;
  logic [5:0] highDataBits;
  logic [3:0] awaddr, araddr, wstrb;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  int err_count, comparisons, n;
  logic [33:0] readQ[$];
  logic [8:0] byteQ[$];
  // Shared select and enable wires: the converter wins while it drives them.
  assign ceLoadIn = ceLoadOe ? ceLoadOut : ceBench;
  assign lowByteEnableIn = lowByteEnableOe ? lowByteEnableOut : lowBench;
  assign highByteEnableIn = highByteEnableOe ? highByteEnableOut : highBench;
  always #4 clk = ~clk;
  always @(posedge clk) oscIn <= ~oscIn;
  iac_converter_ctrl #(.DivRatio(4)) dut_u (.clk(clk), .rst(rst), .oscIn(oscIn),
    .clockSourceSelect(cssBench), .runHold(runHold), .modeIn(modeIn),
    .transmitHoldingEmptyFlag(permit), .comparatorIn(comparatorIn), .testGrounded(testGnd),
    .testMidLevel(testMid), .statusOut(statusOut), .ceLoadIn(ceLoadIn), .ceLoadOut(ceLoadOut),
    .ceLoadOe(ceLoadOe), .lowByteEnableIn(lowByteEnableIn), .lowByteEnableOut(lowByteEnableOut),
    .lowByteEnableOe(lowByteEnableOe), .highByteEnableIn(highByteEnableIn),
    .highByteEnableOut(highByteEnableOut), .highByteEnableOe(highByteEnableOe),
    .lowDataByteBits(lowDataByteBits), .lowDataOe(lowDataOe), .highDataBits(highDataBits),
    .highDataOe(highDataOe), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
  iac_uart_model uart_u (.clk(clk), .rst(rst), .ceLoadOut(ceLoadOut), .ceLoadOe(ceLoadOe),
    .highByteEnableOut(highByteEnableOut), .lowDataByteBits(lowDataByteBits),
    .lowDataOe(lowDataOe), .highDataBits(highDataBits), .highDataOe(highDataOe),
    .stall(stall), .permit(permit), .gotByte(gotByte), .byteData(byteData),
    .byteHigh(byteHigh));
  ////////////////////////////////////////////////////////////////////////////
  task automatic tally(input string what, input logic [33:0] exp, input logic [33:0] got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cmpRead(input logic [33:0] exp, input logic [33:0] got);
    tally("register read", exp, got);
  endtask
  task automatic cmpByte(input logic [8:0] exp, input logic [8:0] got);
    tally("sent byte", {25'h0, exp}, {25'h0, got});
  endtask
  task automatic cmpPin(input string what, input logic [31:0] exp, input logic [31:0] got);
    tally(what, {2'b00, exp}, {2'b00, got});
  endtask
  task automatic wrap_up();
    $display("counts: comparisons %0d, err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic timeout(input string what);
    err_count++;
    $display("wrong value %s expected an answer seen none", what);
    wrap_up();
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic axiWrite(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    bit awDone, wDone;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    awDone = 0;
    wDone = 0;
    for (int k = 0; !(awDone && wDone); k++) begin
      if (k > 100) timeout("write address or data");
      @(negedge clk);
      if (awready === 1'b1 && awvalid) awDone = 1;
      if (wready === 1'b1 && wvalid) wDone = 1;
      @(posedge clk);
      if (awDone) awvalid <= 1'b0;
      if (wDone) wvalid <= 1'b0;
    end
    bready <= 1'b1;
    n = 0;
    do begin @(negedge clk); n++; end while (bvalid !== 1'b1 && n < 100);
    if (n >= 100) timeout("write response");
    cmpPin("bresp", {30'h0, er}, {30'h0, bresp});
    @(posedge clk);
    bready <= 1'b0;
  endtask
  task automatic axiRead(input logic [3:0] a, input logic [33:0] exp);
    readQ.push_back(exp);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do begin @(negedge clk); n++; end while (arready !== 1'b1 && n < 100);
    if (n >= 100) timeout("read address");
    @(posedge clk);
    arvalid <= 1'b0;
    n = 0;
    do begin @(negedge clk); n++; end while (rvalid !== 1'b1 && n < 100);
    if (n >= 100) timeout("read data");
    @(posedge clk);
    rready <= 1'b0;
  endtask
  task automatic waitStatus(input logic lvl, input int bound);
    n = 0;
    while (statusOut !== lvl) begin
      @(negedge clk);
      n++;
      if (n > bound) timeout("status");
    end
  endtask
  // Results are taken off the queues in the order they were noted.
  always @(negedge clk) begin
    if (rvalid === 1'b1 && rready === 1'b1) cmpRead(readQ.pop_front(), {rresp, rdata});
    if (gotByte === 1'b1) cmpByte(byteQ.pop_front(), {byteHigh, byteData});
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {clk, oscIn, runHold, modeIn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    {rst, comparatorIn, ceBench, lowBench, highBench} = 5'h1F;
    {cssBench, testGnd, testMid} = 3'b100;
    wstrb = 4'hF;
    stall = 8'h0A;
    err_count = 0;
    comparisons = 0;
    void'($urandom(32'h7ee6_0951));
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    cmpPin("ceLoadOe", 32'h0, {31'h0, ceLoadOe});
    axiRead(ADDR_CTRL, {RESP_OKAY, 32'h0000_0000});
    axiRead(4'hC, {RESP_SLVERR, 32'h0000_0000});
    axiWrite(4'hC, 32'h0000_0003, RESP_SLVERR);
    axiWrite(ADDR_CTRL, 32'h0000_0001, RESP_OKAY);
    axiRead(ADDR_CTRL, {RESP_OKAY, 32'h0000_0001});
    axiWrite(ADDR_CTRL, 32'h0000_0000, RESP_OKAY);
    $display("test registers done");
    for (int i = 0; i < 8; i++) begin
      {ceBench, lowBench, highBench} <= i[2:0];
      @(negedge clk);
      cmpPin("lowDataOe", {31'h0, !i[2] && !i[1]}, {31'h0, lowDataOe});
      cmpPin("highDataOe", {31'h0, !i[2] && !i[0]}, {31'h0, highDataOe});
      cmpPin("pin enables", 32'h0, {30'h0, ceLoadOe, lowByteEnableOe});
      @(posedge clk);
    end
    $display("test direct decode done");
    {ceBench, lowBench, highBench} <= 3'b000;
    runHold <= 1'b1;
    waitStatus(1'b1, 12000);
    @(posedge clk);
    runHold <= 1'b0;
    waitStatus(1'b0, 20000);
    n = n / 2;
    cmpPin("status ticks", 6144, (n >= 6143 && n <= 6145) ? 6144 : n);
    repeat (2) @(negedge clk);
    cmpPin("low byte", 32'h0000_00FF, {24'h0, lowDataByteBits});
    cmpPin("high group", 32'h0000_003F, {26'h0, highDataBits});
    @(posedge clk);
    axiRead(ADDR_RESULT, {RESP_OKAY, 32'h0000_3FFF});
    repeat (4200) @(posedge clk);
    cssBench <= 1'b0;
    repeat (200) @(posedge clk);
    {cssBench, testMid} <= 2'b11;
    repeat (2) @(negedge clk);
    cmpPin("transparent low byte", 32'h0, {24'h0, lowDataByteBits});
    @(posedge clk);
    {testMid, testGnd} <= 2'b01;
    axiRead(ADDR_STAT, {RESP_OKAY, 32'h0000_01FF});
    testGnd <= 1'b0;
    repeat (20) @(posedge clk);
    axiRead(ADDR_STAT, {RESP_OKAY, 32'h0000_0100});
    repeat (600) @(posedge clk);
    cmpPin("held status", 32'h0, {31'h0, statusOut});
    cmpPin("held low byte", 32'h0000_00FF, {24'h0, lowDataByteBits});
    $display("test direct conversion done");
    comparatorIn <= 1'b0;
    modeIn <= 1'b1;
    stall <= 8'($urandom_range(60, 3));
    byteQ.push_back(9'h12F);
    byteQ.push_back(9'h0FF);
    @(negedge clk);
    cmpPin("handshake enables", 32'h7, {29'h0, ceLoadOe, lowByteEnableOe, highByteEnableOe});
    @(posedge clk);
    runHold <= 1'b1;
    waitStatus(1'b1, 40);
    cmpPin("start delay", 32'h1, {31'h0, n <= 15});
    repeat (30) @(posedge clk);
    runHold <= 1'b0;
    waitStatus(1'b0, 20000);
    n = 0;
    while (byteQ.size() != 0) begin
      @(negedge clk);
      n++;
      if (n > 3000) timeout("handshake bytes");
    end
    @(posedge clk);
    modeIn <= 1'b0;
    repeat (8) @(negedge clk);
    cmpPin("direct again", 32'h0, {31'h0, ceLoadOe});
    $display("test handshake done");
    wrap_up();
  end
endmodule
